// [core/one_wire_debug_pkg.sv]
// constants, encodings and state type for the one-wire debug port break/enable logic
// assumes a single 200 MHz clock and a shared open-drain line with an external debugger
// Behaviour
// - error state: one break resets; two always
// - break sampled with last stored sync baud
// - clock select 1/2/3 = 16/8/4 MHz, resets 3
// - no characters before enable sequence completes
// - fuse field 1: take pin, input with pull-up
// - falling edge: request clock, hold line low
package one_wire_debug_pkg;

	// one-hot port states
	typedef enum logic [6:0] {
		ST_OFF       = 7'h01,
		ST_WAIT_EDGE = 7'h02,
		ST_CLK_WAIT  = 7'h04,
		ST_RELEASE   = 7'h08,
		ST_SYNC      = 7'h10,
		ST_ACTIVE    = 7'h20,
		ST_ERROR     = 7'h40
	} state_type;

	// reset pin configuration value that hands the pin to the port
	localparam logic [1:0] FUSE_DEBUG_PIN = 2'h1;

	// debug clock select encodings
	localparam logic [1:0] SEL_16MHZ = 2'h1;
	localparam logic [1:0] SEL_8MHZ  = 2'h2;
	localparam logic [1:0] SEL_4MHZ  = 2'h3;
	localparam logic [1:0] SEL_RESET = SEL_4MHZ;

	// synchroniser: bit index of each external input
	localparam int SYNC_BITS = 4;
	localparam int SYNC_LINE = 0;
	localparam int SYNC_RDY  = 1;
	localparam int SYNC_FUSE = 2;

	// widths of the timing counters
	localparam int LOW_W  = 24;
	localparam int MEAS_W = 23;
	localparam int BAUD_W = 20;

	// sync character 0x55 gives falling edges every two bits; first to fifth spans 8 bits
	localparam logic [2:0] SYNC_LAST_EDGE = 3'h4;
	localparam int         BAUD_SHIFT     = 3;

	// a break is the line low for a full frame of bit times
	localparam logic [LOW_W-1:0]  BREAK_BITS   = 24'h00000c;
	localparam logic [BAUD_W-1:0] MIN_BIT_CYC  = 20'h00004;
	localparam logic [BAUD_W-1:0] INIT_BIT_CYC = 20'h01000;
	localparam logic [LOW_W-1:0]  LOW_MAX      = 24'hffffff;
	localparam logic [MEAS_W-1:0] MEAS_MAX     = 23'h7fffff;

endpackage

// [core/one_wire_debug_break_enable.sv]
// break reset, sync baud capture and enable sequence of the one-wire debug port
// assumes the pad resolves line_o/line_oe_o and the pull-up; clock_ready_i comes from
// the clock controller and the fuse field from the fuse block, both asynchronous here
`timescale 1ns/10ps

module one_wire_debug_break_enable (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        line_i,
	input  wire logic        clock_ready_i,
	input  wire logic [1:0]  reset_pin_config_i,
	input  wire logic [1:0]  debug_clock_select_i,
	input  wire logic        clock_select_load_i,
	output logic             line_o,
	output logic             line_oe_o,
	output logic             pullup_en_o,
	output logic             clock_req_o,
	output logic             port_enabled_o,
	output logic             port_error_o,
	output logic             break_pulse_o,
	output logic [1:0]       debug_clock_select_o,
	output logic [19:0]      bit_time_o
);

	localparam int SB = one_wire_debug_pkg::SYNC_BITS;

	logic [SB-1:0]                             s1_ff, s2_ff, s3_ff, stable_ff, nxt_stable;
	logic                                      line_prev_ff;
	logic                                      line_lvl, fall, clk_rdy, fuse_ok, listen, brk;
	logic [1:0]                                fuse_lvl;
	logic [one_wire_debug_pkg::LOW_W-1:0]      low_cnt_ff, nxt_low, brk_thresh;
	logic [one_wire_debug_pkg::MEAS_W-1:0]     meas_ff, nxt_meas;
	logic [one_wire_debug_pkg::BAUD_W-1:0]     baud_ff, nxt_baud, new_baud;
	logic [2:0]                                fe_cnt_ff, nxt_fe;
	one_wire_debug_pkg::state_type             state_ff, nxt_state;
	logic                                      nxt_oe, nxt_pullup, nxt_req, nxt_en, nxt_err;
	logic [1:0]                                nxt_sel;

	// pin and cross-domain inputs: three stages, a change counts once stages 2 and 3 agree
	assign fuse_lvl = {stable_ff[one_wire_debug_pkg::SYNC_FUSE + 1],
		stable_ff[one_wire_debug_pkg::SYNC_FUSE]};
	generate
		for (genvar i = 0; i < SB; i++) begin : g_sync
			always_comb begin
				nxt_stable[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : stable_ff[i];
			end
		end
	endgenerate

	// the line idles high through the pull-up, so reset to high to avoid a false edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_ff        <= 4'hd;
			s2_ff        <= 4'hd;
			s3_ff        <= 4'hd;
			stable_ff    <= 4'hd;
			line_prev_ff <= 1'b1;
		end else begin
			s1_ff        <= {reset_pin_config_i, clock_ready_i, line_i};
			s2_ff        <= s1_ff;
			s3_ff        <= s2_ff;
			stable_ff    <= nxt_stable;
			line_prev_ff <= stable_ff[one_wire_debug_pkg::SYNC_LINE];
		end
	end

	assign line_lvl = stable_ff[one_wire_debug_pkg::SYNC_LINE];
	assign clk_rdy  = stable_ff[one_wire_debug_pkg::SYNC_RDY];
	assign fall     = line_prev_ff & ~line_lvl;
	assign fuse_ok  = (fuse_lvl == one_wire_debug_pkg::FUSE_DEBUG_PIN);
	assign listen   = (state_ff == one_wire_debug_pkg::ST_SYNC) ||
		(state_ff == one_wire_debug_pkg::ST_ACTIVE) || (state_ff == one_wire_debug_pkg::ST_ERROR);
	// break threshold scales with the last stored bit time, so no fresh sync is needed
	assign brk_thresh = one_wire_debug_pkg::LOW_W'(baud_ff * one_wire_debug_pkg::BREAK_BITS);
	assign brk        = listen && !line_lvl && (low_cnt_ff == brk_thresh - 24'h000001);
	assign new_baud   = meas_ff[one_wire_debug_pkg::MEAS_W-1:one_wire_debug_pkg::BAUD_SHIFT];

	// port sequencing: enable handshake, sync capture, break handling
	always_comb begin
		nxt_state = state_ff;
		nxt_fe    = fe_cnt_ff;
		nxt_meas  = meas_ff;
		nxt_baud  = baud_ff;
		// low time restarts on any high level, so two breaks need a stop bit between them
		if (line_lvl)
			nxt_low = '0;
		else if (low_cnt_ff != one_wire_debug_pkg::LOW_MAX)
			nxt_low = low_cnt_ff + 24'h000001;
		else
			nxt_low = low_cnt_ff;
		if (fe_cnt_ff != 3'h0 && meas_ff != one_wire_debug_pkg::MEAS_MAX)
			nxt_meas = meas_ff + 23'h000001;
		case (state_ff)
			one_wire_debug_pkg::ST_OFF: begin
				if (fuse_ok)
					nxt_state = one_wire_debug_pkg::ST_WAIT_EDGE;
			end
			one_wire_debug_pkg::ST_WAIT_EDGE: begin
				if (fall)
					nxt_state = one_wire_debug_pkg::ST_CLK_WAIT;
			end
			one_wire_debug_pkg::ST_CLK_WAIT: begin
				if (clk_rdy)
					nxt_state = one_wire_debug_pkg::ST_RELEASE;
			end
			one_wire_debug_pkg::ST_RELEASE: begin
				// the debugger has to be off the line before we listen
				if (line_lvl) begin
					nxt_state = one_wire_debug_pkg::ST_SYNC;
					nxt_fe    = 3'h0;
				end
			end
			one_wire_debug_pkg::ST_SYNC: begin
				// already initial: a break only restarts the sync hunt, so a double break
				// always ends here whatever state the first one found
				if (brk) begin
					nxt_state = one_wire_debug_pkg::ST_SYNC;
					nxt_fe    = 3'h0;
				end else if (meas_ff == one_wire_debug_pkg::MEAS_MAX) begin
					nxt_state = one_wire_debug_pkg::ST_ERROR;
					nxt_fe    = 3'h0;
				end else if (fall) begin
					if (fe_cnt_ff == 3'h0) begin
						nxt_fe   = 3'h1;
						nxt_meas = 23'h000001; // count whole cycles from first to fifth fall
					end else if (fe_cnt_ff == one_wire_debug_pkg::SYNC_LAST_EDGE) begin
						nxt_fe = 3'h0;
						// a too-short sync is a sampling error; keep the old baud
						if (new_baud >= one_wire_debug_pkg::MIN_BIT_CYC) begin
							nxt_baud  = new_baud;
							nxt_state = one_wire_debug_pkg::ST_ACTIVE;
						end else begin
							nxt_state = one_wire_debug_pkg::ST_ERROR;
						end
					end else begin
						nxt_fe = fe_cnt_ff + 3'h1;
					end
				end
			end
			one_wire_debug_pkg::ST_ACTIVE: begin
				// first break in the active state only lands in error
				if (brk)
					nxt_state = one_wire_debug_pkg::ST_ERROR;
			end
			one_wire_debug_pkg::ST_ERROR: begin
				if (brk) begin
					nxt_state = one_wire_debug_pkg::ST_SYNC;
					nxt_fe    = 3'h0;
				end
			end
			default: nxt_state = one_wire_debug_pkg::ST_OFF;
		endcase
		if (!fuse_ok)
			nxt_state = one_wire_debug_pkg::ST_OFF;
		nxt_oe     = (nxt_state == one_wire_debug_pkg::ST_CLK_WAIT);
		nxt_pullup = (nxt_state != one_wire_debug_pkg::ST_OFF);
		nxt_req    = (nxt_state != one_wire_debug_pkg::ST_OFF) &&
			(nxt_state != one_wire_debug_pkg::ST_WAIT_EDGE);
		nxt_en     = (nxt_state == one_wire_debug_pkg::ST_SYNC) ||
			(nxt_state == one_wire_debug_pkg::ST_ACTIVE) ||
			(nxt_state == one_wire_debug_pkg::ST_ERROR);
		nxt_err    = (nxt_state == one_wire_debug_pkg::ST_ERROR);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff       <= one_wire_debug_pkg::ST_OFF;
			low_cnt_ff     <= '0;
			meas_ff        <= '0;
			fe_cnt_ff      <= 3'h0;
			baud_ff        <= one_wire_debug_pkg::INIT_BIT_CYC;
			line_o         <= 1'b0;
			line_oe_o      <= 1'b0;
			pullup_en_o    <= 1'b0;
			clock_req_o    <= 1'b0;
			port_enabled_o <= 1'b0;
			port_error_o   <= 1'b0;
			break_pulse_o  <= 1'b0;
			bit_time_o     <= one_wire_debug_pkg::INIT_BIT_CYC;
		end else begin
			state_ff       <= nxt_state;
			low_cnt_ff     <= nxt_low;
			meas_ff        <= nxt_meas;
			fe_cnt_ff      <= nxt_fe;
			baud_ff        <= nxt_baud;
			line_o         <= 1'b0;                // the port only ever pulls low
			line_oe_o      <= nxt_oe;
			pullup_en_o    <= nxt_pullup;
			clock_req_o    <= nxt_req;
			port_enabled_o <= nxt_en;
			port_error_o   <= nxt_err;
			break_pulse_o  <= brk;
			bit_time_o     <= nxt_baud;
		end
	end

	// debug clock select: only legal codes are taken, others keep the old setting
	always_comb begin
		nxt_sel = debug_clock_select_o;
		if (clock_select_load_i && debug_clock_select_i != 2'h0)
			nxt_sel = debug_clock_select_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			debug_clock_select_o <= one_wire_debug_pkg::SEL_RESET;
		else
			debug_clock_select_o <= nxt_sel;
	end

	// checks on the sequencing above
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	pullup_in_wait_a: assert property (state_ff == one_wire_debug_pkg::ST_WAIT_EDGE |->
		pullup_en_o && !line_oe_o) else $error("pull-up missing while waiting for edge");
	fuse_off_a: assert property (!fuse_ok |=> state_ff == one_wire_debug_pkg::ST_OFF)
		else $error("port active without fuse");
	edge_request_a: assert property (state_ff == one_wire_debug_pkg::ST_WAIT_EDGE && fall
		&& fuse_ok |=> clock_req_o && line_oe_o && !line_o)
		else $error("no clock request and hold on edge");
	hold_low_a: assert property (state_ff == one_wire_debug_pkg::ST_CLK_WAIT && !clk_rdy
		&& fuse_ok |=> line_oe_o ##0 state_ff == one_wire_debug_pkg::ST_CLK_WAIT)
		else $error("line released before clock ready");
	enable_order_a: assert property ($rose(port_enabled_o) |->
		$past(state_ff) == one_wire_debug_pkg::ST_RELEASE && $past(line_lvl))
		else $error("enabled without completed sequence");
	error_break_a: assert property (state_ff == one_wire_debug_pkg::ST_ERROR && brk && fuse_ok
		|=> state_ff == one_wire_debug_pkg::ST_SYNC ##0 break_pulse_o)
		else $error("single break did not reset from error");
	double_break_a: assert property (state_ff == one_wire_debug_pkg::ST_ACTIVE && brk && fuse_ok
		|=> port_error_o && port_enabled_o)
		else $error("first break did not reach error");
	sync_break_a: assert property (state_ff == one_wire_debug_pkg::ST_SYNC && brk && fuse_ok
		|=> state_ff == one_wire_debug_pkg::ST_SYNC && !port_error_o)
		else $error("break in initial state left it");
	break_keeps_baud_a: assert property (brk |=> bit_time_o == $past(baud_ff))
		else $error("baud changed by break");
	select_reset_a: assert property ($past(rst_i) |-> debug_clock_select_o ==
		one_wire_debug_pkg::SEL_RESET) else $error("clock select not 4 MHz after reset");

	enable_done_c: cover property (state_ff == one_wire_debug_pkg::ST_RELEASE ##1
		state_ff == one_wire_debug_pkg::ST_SYNC);
	sync_learned_c: cover property (state_ff == one_wire_debug_pkg::ST_SYNC ##1
		state_ff == one_wire_debug_pkg::ST_ACTIVE);
	error_reset_c: cover property (state_ff == one_wire_debug_pkg::ST_ERROR && brk);

endmodule

// [verification/debugger_model.sv]
// behavioural external debugger on the shared one-wire debug line
// assumes every task is entered just after a rising clock edge; it only ever pulls low
`timescale 1ns/10ps

module debugger_model (
	input  wire logic clk_i,
	output logic      line_low_o
);
	initial line_low_o = 1'b0;

	// pull or release for n cycles; changes land just after an edge, never on it
	task automatic drive(input logic low, input int n);
		line_low_o = low;
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// low pulse, then release well before the port lets go of the line
	task automatic enable_pulse(input int n);
		drive(1'b1, n);
		drive(1'b0, 1);
	endtask

	// 0x55 lsb first with start and stop bits: low on even bit slots
	task automatic send_sync(input int bt);
		for (int i = 0; i < 10; i++) begin
			drive(i % 2 == 0, bt);
		end
		drive(1'b0, bt);
	endtask

	// break longer than a frame, so a slow stored baud still sees it, then stop bits
	task automatic send_break(input int bt);
		drive(1'b1, 14 * bt);
		drive(1'b0, 2 * bt);
	endtask
endmodule

// [verification/tb.sv]
// self-checking bench for the one-wire debug port break and enable logic
// assumes the debugger model on the line and a 200 MHz clock; the pad is resolved here
`timescale 1ns/10ps

module tb;
	logic        clk_i;
	logic        rst_i;
	logic        clock_ready_i;
	logic [1:0]  reset_pin_config_i;
	logic [1:0]  debug_clock_select_i;
	logic        clock_select_load_i;
	logic        line_o;
	logic        line_oe_o;
	logic        pullup_en_o;
	logic        clock_req_o;
	logic        port_enabled_o;
	logic        port_error_o;
	logic        break_pulse_o;
	logic [1:0]  debug_clock_select_o;
	logic [19:0] bit_time_o;
	logic        dbg_low;
	logic        float_pat;
	wire         line_w;
	int          failures;
	int          n_compared;
	int          n_breaks;
	int          cycles;
	int          b0;

	// an undriven pad without pull-up wanders, so feed a toggling level there
	assign line_w = dbg_low ? 1'b0 : line_oe_o ? line_o : pullup_en_o ? 1'b1 : float_pat;

	one_wire_debug_break_enable dut (
		.clk_i                (clk_i),
		.rst_i                (rst_i),
		.line_i               (line_w),
		.clock_ready_i        (clock_ready_i),
		.reset_pin_config_i   (reset_pin_config_i),
		.debug_clock_select_i (debug_clock_select_i),
		.clock_select_load_i  (clock_select_load_i),
		.line_o               (line_o),
		.line_oe_o            (line_oe_o),
		.pullup_en_o          (pullup_en_o),
		.clock_req_o          (clock_req_o),
		.port_enabled_o       (port_enabled_o),
		.port_error_o         (port_error_o),
		.break_pulse_o        (break_pulse_o),
		.debug_clock_select_o (debug_clock_select_o),
		.bit_time_o           (bit_time_o)
	);

	debugger_model dbg (
		.clk_i      (clk_i),
		.line_low_o (dbg_low)
	);

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// break pulse count, toggling float level and the hang limit
	always @(posedge clk_i) begin
		float_pat <= ~float_pat;
		if (break_pulse_o === 1'b1) n_breaks++;
		cycles++;
		if (cycles == 40000) begin
			failures++;
			report_and_stop();
		end
	end

	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		if (failures == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic wait_cycles(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// codes 1..3 load, code 0 is ignored and the last code stays
	task automatic t_clock_select();
		logic [1:0] codes [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
		logic [1:0] exps [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
		check(debug_clock_select_o, 20'h00003);
		for (int i = 0; i < 4; i++) begin
			debug_clock_select_i = codes[i];
			clock_select_load_i = 1'b1;
			wait_cycles(1);
			clock_select_load_i = 1'b0;
			wait_cycles(1);
			check(debug_clock_select_o, exps[i]);
		end
	endtask

	// wandering line without fuse is ignored; fuse 1 grants pull-up; enable handshake
	task automatic t_enable();
		reset_pin_config_i = 2'h2;
		wait_cycles(30);
		check({pullup_en_o, clock_req_o, line_oe_o}, 20'h00000);
		reset_pin_config_i = 2'h1;
		for (int k = 0; k < 20 && pullup_en_o !== 1'b1; k++) wait_cycles(1);
		check(pullup_en_o, 20'h00001);
		check(line_w, 20'h00001);
		check(port_enabled_o, 20'h00000);
		dbg.enable_pulse(20);
		wait_cycles(10);
		check({clock_req_o, line_oe_o, line_w}, 20'h00006);
		wait_cycles(50);
		check({line_oe_o, line_w, port_enabled_o}, 20'h00004);
		clock_ready_i = 1'b1;
		for (int k = 0; k < 20 && port_enabled_o !== 1'b1; k++) wait_cycles(1);
		check({line_oe_o, line_w, port_enabled_o}, 20'h00003);
	endtask

	// sync learns 8 cycles; double break from active leaves the port resynchronising
	task automatic t_sync_breaks();
		dbg.send_sync(8);
		check(bit_time_o, 20'h00008);
		check(port_error_o, 20'h00000);
		b0 = n_breaks;
		dbg.send_break(8);
		check(port_error_o, 20'h00001);
		dbg.send_break(8);
		check(n_breaks - b0, 20'h00002);
		check({port_error_o, port_enabled_o}, 20'h00001);
	endtask

	// too fast a sync errors and keeps the old baud; one break then clears the error
	task automatic t_bad_sync();
		dbg.send_sync(2);
		wait_cycles(6);
		check(port_error_o, 20'h00001);
		check(bit_time_o, 20'h00008);
		b0 = n_breaks;
		dbg.send_break(8);
		check(n_breaks - b0, 20'h00001);
		check({port_error_o, port_enabled_o}, 20'h00001);
		dbg.send_break(8);
		check(n_breaks - b0, 20'h00002);
		check({port_error_o, port_enabled_o}, 20'h00001);
	endtask

	// reset in mid-run restores defaults, then the enable handshake runs again
	task automatic t_mid_reset();
		debug_clock_select_i = 2'h1;
		clock_select_load_i = 1'b1;
		wait_cycles(1);
		clock_select_load_i = 1'b0;
		rst_i = 1'b1;
		clock_ready_i = 1'b0;
		wait_cycles(4);
		rst_i = 1'b0;
		check(bit_time_o, 20'h01000);
		check(debug_clock_select_o, 20'h00003);
		check({pullup_en_o, port_enabled_o, port_error_o, line_oe_o}, 20'h00000);
		t_enable();
	endtask

	// losing the fuse field hands the pin back
	task automatic t_fuse_loss();
		reset_pin_config_i = 2'h0;
		wait_cycles(10);
		check({pullup_en_o, clock_req_o, port_enabled_o}, 20'h00000);
	endtask

	initial begin
		failures = 0;
		n_compared = 0;
		n_breaks = 0;
		cycles = 0;
		float_pat = 1'b0;
		rst_i = 1'b1;
		clock_ready_i = 1'b0;
		reset_pin_config_i = 2'h0;
		debug_clock_select_i = 2'h0;
		clock_select_load_i = 1'b0;
		wait_cycles(20);
		rst_i = 1'b0;
		check(bit_time_o, 20'h01000);
		check({port_enabled_o, port_error_o, line_oe_o}, 20'h00000);
		t_clock_select();
		t_enable();
		t_sync_breaks();
		t_bad_sync();
		t_fuse_loss();
		t_mid_reset();
		t_sync_breaks();
		report_and_stop();
	end
endmodule
